/* File: hw/acc_top.sv */
`timescale 1ns/1ns
module acc_top #(
  parameter int unsigned CONV_CYCLES = acc_pkg::CONV_CYCLES_DEF
) (
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic [11:0]    s_axi_awaddr,
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  input  wire logic [11:0]    s_axi_araddr,
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  input  wire logic [11:0]    adc_sample,
  output acc_pkg::acc_fe_t    fe_ctrl,
  output logic [11:0]         adc_result,
  output logic                irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]               calsc_r;
  logic [3:0]               sel_r;
  logic [11:0]              result_r;
  logic [11:0]              ofs_coef_r;
  logic [11:0]              gain_coef_r;
  logic [acc_pkg::INT_W-1:0] int_stat_r;
  logic [acc_pkg::INT_W-1:0] int_mask_r;
  logic                     irq_r;
  acc_pkg::acc_fe_t         fe_r;
  acc_pkg::acc_state_t      state_r;
  logic [15:0]              tick_r;
  logic [5:0]               rd_cnt_r;
  logic [5:0]               hits_r;
  logic [3:0]               bit_r;
  logic [11:0]              cal_code_r;

  logic                     aw_hold_r;
  logic                     w_hold_r;
  logic [11:0]              awaddr_r;
  logic [31:0]              wdata_r;
  logic [3:0]               wstrb_r;
  logic                     awready_r;
  logic                     wready_r;
  logic                     bvalid_r;
  logic [1:0]               bresp_r;
  logic                     arready_r;
  logic                     rvalid_r;
  logic [31:0]              rdata_r;
  logic [1:0]               rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // write decode

  wire wr_fire  = aw_hold_r & w_hold_r & ~bvalid_r;
  wire wr_calsc = wr_fire & (awaddr_r == acc_pkg::ADDR_CALSC);
  wire wr_ctrl  = wr_fire & (awaddr_r == acc_pkg::ADDR_CTRL);
  wire wr_ofs   = wr_fire & (awaddr_r == acc_pkg::ADDR_OFS_COEF);
  wire wr_gain  = wr_fire & (awaddr_r == acc_pkg::ADDR_GAIN_COEF);
  wire wr_stat  = wr_fire & (awaddr_r == acc_pkg::ADDR_INT_STAT);
  wire wr_mask  = wr_fire & (awaddr_r == acc_pkg::ADDR_INT_MASK);
  wire wr_hit   = wr_calsc | wr_ctrl | wr_ofs | wr_gain | wr_stat | wr_mask;
  wire b0       = wstrb_r[0];
  wire b1       = wstrb_r[1];

  wire [11:0] w12 = {b1 ? wdata_r[11:8] : 4'h0, wdata_r[7:0]};

  function automatic logic [11:0] merge12(input logic [11:0] old, input logic [11:0] nw,
                                          input logic s0, input logic s1);
    merge12 = {s1 ? nw[11:8] : old[11:8], s0 ? nw[7:0] : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // source selection

  // select and start may share one write; codes 13..15 join the invalid path
  wire [3:0] sel_eff = (wr_ctrl & b0) ? wdata_r[acc_pkg::CTRL_SEL_LSB +: 4] : sel_r; // [RULE1]
  wire sel_ext   = (sel_eff <= acc_pkg::SRC_EXT_LAST);                    // [RULE1]
  wire sel_int   = (sel_eff >= acc_pkg::SRC_TEMP) & (sel_eff <= acc_pkg::SRC_VREF); // [RULE3]
  wire sel_valid = sel_ext | sel_int;                                      // [RULE2]

  wire conv_req  = wr_ctrl & b1 & wdata_r[acc_pkg::CTRL_CONV_BIT];
  wire idle      = (state_r == acc_pkg::ST_IDLE);
  // a start written during a conversion waits in the start bit until idle
  wire cal_go    = idle & calsc_r[acc_pkg::BIT_CAL_START];                 // [RULE12]
  wire conv_go   = idle & ~cal_go & conv_req & sel_valid;
  wire conv_bad  = conv_req & ~sel_valid;                                  // [RULE2]

  wire [1:0] avg_code = calsc_r[acc_pkg::BIT_AVG_HI:acc_pkg::BIT_AVG_LO];
  wire [5:0] avg_n    = (avg_code == 2'b00) ? acc_pkg::AVG_N0 :            // [RULE8]
                        (avg_code == 2'b01) ? acc_pkg::AVG_N1 :
                        (avg_code == 2'b10) ? acc_pkg::AVG_N2 : acc_pkg::AVG_N3;

  wire cal_is_gain = calsc_r[acc_pkg::BIT_CAL_TYPE];                       // [RULE11]
  wire [3:0] cal_src = cal_is_gain ? acc_pkg::SRC_VREF : acc_pkg::SRC_GND; // [RULE11]

  ////////////////////////////////////////////////////////////////////////////
  // reading timer and bit decisions

  wire        tick_end  = (tick_r == 16'(CONV_CYCLES - 1));
  wire [11:0] trial     = cal_code_r | (12'h001 << bit_r);
  wire        above     = (adc_sample >= trial);
  wire [5:0]  hits_nxt  = hits_r + 6'(above);
  wire        last_rd   = (rd_cnt_r == avg_n - 6'd1);
  // majority of the averaged readings decides the bit
  wire        keep_bit  = ({1'b0, hits_nxt, 1'b0} > {2'b00, avg_n});
  wire [11:0] code_nxt  = keep_bit ? trial : cal_code_r;
  wire        cal_end   = (state_r == acc_pkg::ST_CAL) & tick_end & last_rd & (bit_r == 4'd0);
  wire        conv_end  = (state_r == acc_pkg::ST_CONV) & tick_end;

  ////////////////////////////////////////////////////////////////////////////
  // coefficient correction

  wire              ofs_on   = ~calsc_r[acc_pkg::BIT_OFS_BYP];             // [RULE9]
  wire              gain_on  = ~calsc_r[acc_pkg::BIT_GAIN_BYP];            // [RULE7]
  wire signed [13:0] raw_ofs = $signed({2'b00, adc_sample}) -
                               $signed({2'b00, ofs_on ? ofs_coef_r : 12'h000}); // [RULE9]
  wire signed [13:0] trim    = $signed({2'b00, acc_pkg::FULL_SCALE}) -
                               $signed({2'b00, gain_coef_r});
  wire signed [27:0] prod    = raw_ofs * trim;
  wire signed [15:0] adj     = gain_on ? 16'(prod >>> 12) : 16'sd0;        // [RULE7]
  wire signed [15:0] corr    = 16'(raw_ofs) + adj;
  wire [11:0]        corr_sat = corr[15] ? 12'h000 :
                                (corr > $signed({4'h0, acc_pkg::FULL_SCALE})) ?
                                acc_pkg::FULL_SCALE : corr[11:0];

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events

  wire [acc_pkg::INT_W-1:0] ev = {conv_bad, cal_end, conv_end};
  wire [acc_pkg::INT_W-1:0] stat_clr = (wr_stat & b0) ? wdata_r[acc_pkg::INT_W-1:0] : '0;
  // set wins over a clear in the same cycle
  wire [acc_pkg::INT_W-1:0] stat_nxt = (int_stat_r & ~stat_clr) | ev;

  ////////////////////////////////////////////////////////////////////////////
  // calibration/status register next value

  logic [7:0] calsc_nxt;
  always_comb begin
    calsc_nxt = calsc_r;
    if (wr_calsc & b0) begin
      calsc_nxt[6:1] = wdata_r[6:1];
      // writing 0 cannot abort a pending or running calibration
      calsc_nxt[acc_pkg::BIT_CAL_START] = calsc_r[acc_pkg::BIT_CAL_START] |
                                          wdata_r[acc_pkg::BIT_CAL_START]; // [RULE12]
    end
    if (cal_end) begin
      calsc_nxt[acc_pkg::BIT_CAL_START] = 1'b0;                            // [RULE13]
    end
    calsc_nxt[acc_pkg::BIT_BUSY] = (state_r != acc_pkg::ST_IDLE) & ~cal_end & ~conv_end; // [RULE6]
    if (cal_go | conv_go) begin
      calsc_nxt[acc_pkg::BIT_BUSY] = 1'b1;                                 // [RULE5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= acc_pkg::ST_IDLE;
      tick_r     <= '0;
      rd_cnt_r   <= '0;
      hits_r     <= '0;
      bit_r      <= '0;
      cal_code_r <= '0;
    end else begin
      case (state_r)
        acc_pkg::ST_IDLE: begin
          tick_r     <= '0;
          rd_cnt_r   <= '0;
          hits_r     <= '0;
          bit_r      <= 4'd11;
          cal_code_r <= '0;
          if (cal_go) begin
            state_r <= acc_pkg::ST_CAL;                                   // [RULE12]
          end else if (conv_go) begin
            state_r <= acc_pkg::ST_CONV;                                  // [RULE1]
          end
        end
        acc_pkg::ST_CONV: begin
          tick_r <= tick_r + 16'd1;
          if (tick_end) begin
            state_r <= acc_pkg::ST_IDLE;                                  // [RULE6]
          end
        end
        acc_pkg::ST_CAL: begin
          tick_r <= tick_end ? 16'd0 : tick_r + 16'd1;
          if (tick_end) begin
            hits_r   <= last_rd ? 6'd0 : hits_nxt;
            rd_cnt_r <= last_rd ? 6'd0 : rd_cnt_r + 6'd1;                 // [RULE8]
            if (last_rd) begin
              cal_code_r <= code_nxt;
              bit_r      <= bit_r - 4'd1;
              if (bit_r == 4'd0) begin
                state_r <= acc_pkg::ST_IDLE;                              // [RULE13]
              end
            end
          end
        end
        default: state_r <= acc_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      calsc_r     <= acc_pkg::CALSC_RST;                                  // [RULE4]
      sel_r       <= '0;
      result_r    <= '0;
      ofs_coef_r  <= acc_pkg::OFS_COEF_RST;
      gain_coef_r <= acc_pkg::GAIN_COEF_RST;
      int_stat_r  <= '0;
      int_mask_r  <= '0;
      irq_r       <= 1'b0;
    end else begin
      calsc_r    <= calsc_nxt;
      int_stat_r <= stat_nxt;
      irq_r      <= |(stat_nxt & int_mask_r);
      if (wr_ctrl & b0) begin
        sel_r <= wdata_r[acc_pkg::CTRL_SEL_LSB +: 4];
      end
      if (wr_mask & b0) begin
        int_mask_r <= wdata_r[acc_pkg::INT_W-1:0];
      end
      if (conv_end) begin
        result_r <= corr_sat;                                             // [RULE7]
      end
      // calibration result overrides a software write in the same cycle
      if (cal_end & ~cal_is_gain) begin
        ofs_coef_r <= code_nxt;                                           // [RULE11]
      end else if (wr_ofs) begin
        ofs_coef_r <= merge12(ofs_coef_r, w12, b0, b1);
      end
      if (cal_end & cal_is_gain) begin
        gain_coef_r <= code_nxt;                                          // [RULE11]
      end else if (wr_gain) begin
        gain_coef_r <= merge12(gain_coef_r, w12, b0, b1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // front end control

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fe_r <= '0;
    end else begin
      fe_r.sampling     <= (state_r != acc_pkg::ST_IDLE) & ~cal_end & ~conv_end;
      fe_r.gain_apply   <= gain_on;
      fe_r.offset_apply <= ofs_on;
      if (cal_go) begin
        fe_r.src_code  <= cal_src;                                        // [RULE11]
        fe_r.src_valid <= 1'b1;
        fe_r.sampling  <= 1'b1;
      end else if (idle) begin
        fe_r.src_code  <= sel_valid ? sel_eff : 4'h0;                     // [RULE3]
        fe_r.src_valid <= sel_valid;                                      // [RULE2]
        fe_r.sampling  <= conv_go;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'b00;
    end else begin
      if (s_axi_awvalid & awready_r) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[11:2], 2'b00};
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid & wready_r) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? 2'b00 : 2'b10;
      end
      if (bvalid_r & s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  wire [11:0] ra = {s_axi_araddr[11:2], 2'b00};
  wire        rd_hit = (ra == acc_pkg::ADDR_CALSC) | (ra == acc_pkg::ADDR_CTRL) |
                       (ra == acc_pkg::ADDR_RESULT) | (ra == acc_pkg::ADDR_OFS_COEF) |
                       (ra == acc_pkg::ADDR_GAIN_COEF) | (ra == acc_pkg::ADDR_INT_STAT) |
                       (ra == acc_pkg::ADDR_INT_MASK);
  // conversion start reads back as zero: it is a strobe, busy shows progress
  wire [31:0] rd_mux =
    (ra == acc_pkg::ADDR_CALSC)     ? {24'h0, calsc_r} :                  // [RULE5]
    (ra == acc_pkg::ADDR_CTRL)      ? {28'h0, sel_r} :
    (ra == acc_pkg::ADDR_RESULT)    ? {20'h0, result_r} :
    (ra == acc_pkg::ADDR_OFS_COEF)  ? {20'h0, ofs_coef_r} :
    (ra == acc_pkg::ADDR_GAIN_COEF) ? {20'h0, gain_coef_r} :
    (ra == acc_pkg::ADDR_INT_STAT)  ? {29'h0, int_stat_r} :
    (ra == acc_pkg::ADDR_INT_MASK)  ? {29'h0, int_mask_r} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= 2'b00;
    end else begin
      if (s_axi_arvalid & arready_r) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_mux;
        rresp_r   <= rd_hit ? 2'b00 : 2'b10;
      end
      if (rvalid_r & s_axi_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign fe_ctrl       = fe_r;
  assign adc_result    = result_r;
  assign irq           = irq_r;
endmodule

/* File: hw/acc_pkg.sv */
// Notes on behaviour
// [RULE1] convert the input named by channel select
// [RULE2] codes 0110, 0111 invalid, no channel connected
// [RULE3] codes 1000-1100 route the internal sources
// [RULE4] cal/status register at F5H, resets to 00H
// [RULE5] bit 7 busy, read-only, whole cycle
// [RULE6] busy clears itself when cycle ends
// [RULE7] bit 6 set bypasses gain coefficient
// [RULE8] bits 5:4 readings per decision, 15..63
// [RULE9] bit 3 set bypasses offset coefficient
// [RULE10] software sets cal mode bit before calibrating
// [RULE11] bit 1 picks offset or gain calibration
// [RULE12] writing 1 to bit 0 starts calibration
// [RULE13] start bit clears when calibration completes
package acc_pkg;

  // register indices / byte addresses
  localparam logic [11:0] CALSC_INDEX    = 12'h0F5;                    // [RULE4]
  localparam logic [11:0] ADDR_CALSC     = 12'(CALSC_INDEX * 4);
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_RESULT    = 12'h004;
  localparam logic [11:0] ADDR_OFS_COEF  = 12'h008;
  localparam logic [11:0] ADDR_GAIN_COEF = 12'h00C;
  localparam logic [11:0] ADDR_INT_STAT  = 12'h010;
  localparam logic [11:0] ADDR_INT_MASK  = 12'h014;

  // reset values
  localparam logic [7:0]  CALSC_RST      = 8'h00;                      // [RULE4]
  localparam logic [11:0] OFS_COEF_RST   = 12'h000;
  localparam logic [11:0] GAIN_COEF_RST  = 12'hFFF;
  localparam logic [11:0] FULL_SCALE     = 12'hFFF;

  // calibration register bits
  localparam int BIT_BUSY      = 7;
  localparam int BIT_GAIN_BYP  = 6;
  localparam int BIT_AVG_HI    = 5;
  localparam int BIT_AVG_LO    = 4;
  localparam int BIT_OFS_BYP   = 3;
  localparam int BIT_CAL_MODE  = 2;
  localparam int BIT_CAL_TYPE  = 1;
  localparam int BIT_CAL_START = 0;

  // control register bits
  localparam int CTRL_SEL_LSB   = 0;
  localparam int CTRL_CONV_BIT  = 8;

  // interrupt bits
  localparam int INT_CONV_DONE = 0;
  localparam int INT_CAL_DONE  = 1;
  localparam int INT_INVALID   = 2;
  localparam int INT_W         = 3;

  // readings averaged per decision, by code
  localparam logic [5:0] AVG_N0 = 6'h0F;
  localparam logic [5:0] AVG_N1 = 6'h1F;
  localparam logic [5:0] AVG_N2 = 6'h2F;
  localparam logic [5:0] AVG_N3 = 6'h3F;

  // source codes
  localparam logic [3:0] SRC_TEMP  = 4'h8;
  localparam logic [3:0] SRC_GND   = 4'hB;
  localparam logic [3:0] SRC_VREF  = 4'hC;
  localparam logic [3:0] SRC_EXT_LAST = 4'h5;

  localparam int unsigned CONV_CYCLES_DEF = 16;

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_CAL} acc_state_t;

  typedef struct packed {
    logic [3:0] src_code;
    logic       src_valid;
    logic       sampling;
    logic       gain_apply;
    logic       offset_apply;
  } acc_fe_t;

endpackage

/* File: tb/acc_top_sva.sv */
`timescale 1ns/1ns
module acc_top_sva #(
  parameter int unsigned CONV_CYCLES = acc_pkg::CONV_CYCLES_DEF
) (
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [31:0]      s_axi_rdata,
  input wire acc_pkg::acc_fe_t fe_ctrl,
  input wire logic             irq
);
  logic [15:0] run_cnt_r;
  logic [1:0]  age_r;
  wire         settled  = (age_r == 2'h3);
  wire         bad_code = fe_ctrl.src_code inside {4'h6, 4'h7, 4'hD, 4'hE, 4'hF};

  // age guard: apply bits may leave their reset value without any write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_cnt_r <= 16'h0000;
      age_r     <= 2'h0;
    end else begin
      run_cnt_r <= fe_ctrl.sampling ? run_cnt_r + 16'h0001 : 16'h0000;
      age_r     <= settled ? age_r : age_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  aw_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  invalid_code_a: assert property (fe_ctrl.src_valid |-> !bad_code)
    else $error("invalid code connected");
  no_channel_a: assert property (!fe_ctrl.src_valid |-> fe_ctrl.src_code == 4'h0)
    else $error("source code without channel");
  sample_src_a: assert property ($rose(fe_ctrl.sampling) |-> fe_ctrl.src_valid)
    else $error("cycle started without source");
  src_steady_a: assert property (fe_ctrl.sampling && $past(fe_ctrl.sampling) |->
      $stable(fe_ctrl.src_code))
    else $error("source moved mid cycle");
  busy_len_a: assert property ($fell(fe_ctrl.sampling) |-> 32'(run_cnt_r) >= CONV_CYCLES)
    else $error("cycle ended too soon");
  // apply bits follow the register one edge after the write that raised bvalid
  gain_write_a: assert property (settled && $changed(fe_ctrl.gain_apply) |->
      $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("gain apply changed without write");
  offset_write_a: assert property (settled && $changed(fe_ctrl.offset_apply) |->
      $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("offset apply changed without write");

  conv_end_c: cover property ($fell(fe_ctrl.sampling));
  cal_end_c: cover property ($fell(fe_ctrl.sampling) && run_cnt_r > 16'h0100);
  irq_c: cover property ($rose(irq));
endmodule

bind acc_top acc_top_sva #(.CONV_CYCLES(CONV_CYCLES)) u_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .fe_ctrl(fe_ctrl), .irq(irq));

/* File: tb/acc_top_tb_top.sv */
`timescale 1ns/1ns
module acc_top_tb_top;
  localparam int unsigned CC  = 16;
  localparam logic [11:0] CAL = acc_pkg::ADDR_CALSC;
  localparam logic [11:0] STA = acc_pkg::ADDR_INT_STAT;
  localparam logic [11:0] MSK = acc_pkg::ADDR_INT_MASK;
  logic             aclk = 1'b0;
  logic             aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic             awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0]      awaddr, araddr, sample, result;
  logic [31:0]      wdata, rdata;
  logic [1:0]       bresp, rresp, resp;
  acc_pkg::acc_fe_t fe;
  int               fail_count, checks;

  always #2 aclk = ~aclk;

  // a small conversion count keeps headroom for reads inside one conversion
  acc_top #(.CONV_CYCLES(CC)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .adc_sample(sample), .fe_ctrl(fe), .adc_result(result), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // no cycle limit: only the watchdog ends a stuck transfer
    while (!b_ok) begin
      @(posedge aclk);
      if (awready && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        b_ok = 1'b1;
        resp = bresp;
        bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    rd(CAL, d);
    chk("cal reset", d, 32'h0);
    chk("cal read resp", 32'(resp), 32'h0);
    rd(12'h020, d);
    chk("unmapped resp", 32'(resp), 32'h2);
    chk("unmapped data", d, 32'h0);
    wr(12'h020, 32'h1);
    chk("unmapped write resp", 32'(resp), 32'h2);
    chk("irq idle", 32'(irq), 32'h0);
    $display("test reset done");
  endtask

  task automatic t_bypass();
    logic [31:0] d;
    wr(CAL, 32'hC8);
    chk("cal write resp", 32'(resp), 32'h0);
    rd(CAL, d);
    chk("busy read only", d, 32'h48);
    chk("gain off", 32'(fe.gain_apply), 32'h0);
    chk("offset off", 32'(fe.offset_apply), 32'h0);
    wr(CAL, 32'h0);
    settle();
    chk("gain on", 32'(fe.gain_apply), 32'h1);
    chk("offset on", 32'(fe.offset_apply), 32'h1);
    $display("test bypass done");
  endtask

  task automatic t_chan();
    logic [31:0] d;
    logic        ok;
    wr(MSK, 32'h7);
    for (int c = 0; c < 16; c++) begin
      ok = !(c inside {6, 7, 13, 14, 15});
      wr(acc_pkg::ADDR_CTRL, 32'h100 | 32'(c));
      #1;
      chk("src valid", 32'(fe.src_valid), 32'(ok));
      chk("src code", 32'(fe.src_code), ok ? 32'(c) : 32'h0);
      rd(CAL, d);
      chk("busy in conv", d, ok ? 32'h80 : 32'h0);
      for (int n = 0; n < 200; n++) begin
        @(posedge aclk);
        if (!fe.sampling) break;
      end
      rd(CAL, d);
      chk("busy cleared", d, 32'h0);
      rd(STA, d);
      chk("event status", d, ok ? 32'h1 : 32'h4);
      chk("irq raised", 32'(irq), 32'h1);
      if (ok) chk("result", 32'(result), 32'h800);
      wr(STA, d);
      settle();
      chk("irq cleared", 32'(irq), 32'h0);
    end
    $display("test channels done");
  endtask

  task automatic t_cal();
    logic [31:0] d;
    logic [31:0] v;
    int          cnt;
    int          exp;
    wr(MSK, 32'h2);
    for (int a = 0; a < 4; a++) begin
      v = 32'(a << 4) | 32'h5 | 32'((a & 1) << 1);
      exp = 12 * (15 + 16 * a) * CC;
      cnt = 0;
      wr(CAL, v);
      for (int n = 0; n < 20000 && !(cnt > 0 && !fe.sampling); n++) begin
        @(posedge aclk);
        if (fe.sampling) cnt++;
        if (cnt == 10) chk("cal source", 32'(fe.src_code), (a & 1) ? 32'hC : 32'hB);
      end
      // exact span: 12 decisions of N readings, each reading one conversion time
      chk("cal length", 32'(cnt), 32'(exp));
      rd(CAL, d);
      chk("cal start cleared", d, v & 32'h7E);
      chk("cal irq", 32'(irq), 32'h1);
      wr(MSK, 32'h0);
      settle();
      chk("irq masked", 32'(irq), 32'h0);
      wr(MSK, 32'h2);
      wr(STA, 32'h2);
      settle();
      chk("irq cleared", 32'(irq), 32'h0);
    end
    $display("test calibration done");
  endtask

  // offset 100 and gain 7FF under each bypass setting, sample fixed at 800
  task automatic t_coef();
    logic [47:0] exp;
    exp = 48'h800700C00A80;
    wr(acc_pkg::ADDR_OFS_COEF, 32'h100);
    wr(acc_pkg::ADDR_GAIN_COEF, 32'h7FF);
    for (int k = 0; k < 4; k++) begin
      wr(CAL, {25'h0, k[1], 2'h0, k[0], 3'h0});
      wr(acc_pkg::ADDR_CTRL, 32'h100);
      repeat (CC + 4) @(posedge aclk);
      chk("corrected result", 32'(result), 32'(exp[12*k +: 12]));
    end
    $display("test coefficients done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, resp} = 58'h0;
    sample = 12'h800;
    fail_count = 0;
    checks = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_bypass();
    t_chan();
    t_cal();
    t_coef();
    end_of_test();
  end
endmodule
